// ---- rtl/usar_defs.vh ----
// Purpose: constants for the ups status and alert reporter
// Assumes: 32-bit avalon-mm data, byte addresses
// Notes:   definitions only
`ifndef USAR_DEFS_VH
`define USAR_DEFS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define USAR_OFF_OPT      6'h00
`define USAR_OFF_COND     6'h04
`define USAR_OFF_MODE     6'h08
`define USAR_OFF_FAULT    6'h0C
`define USAR_OFF_SHUT     6'h10
`define USAR_OFF_CTRL     6'h14
`define USAR_OFF_STAT     6'h18
`define USAR_OFF_HEX_OPT  6'h20
`define USAR_OFF_HEX_COND 6'h24
`define USAR_OFF_HEX_MODE 6'h28
`define USAR_OFF_HEX_FLT  6'h2C
`define USAR_OFF_HEX_SHUT 6'h30
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define USAR_CTRL_RESET    2'h3
`define USAR_CTRL_ALERT_EN 0
`define USAR_CTRL_ENV_EN   1
`define USAR_SHUT_ABN_MASK 8'hE6
`define USAR_NOT_READY     16'h534D
// ----------------------------------------
// alert characters and pending slots
// ----------------------------------------
`define USAR_CH_LINE_FAIL  8'h21
`define USAR_CH_LINE_BACK  8'h24
`define USAR_CH_BATT_LOW   8'h25
`define USAR_CH_BATT_BACK  8'h2B
`define USAR_CH_ABNORMAL   8'h3F
`define USAR_CH_ABN_CLEAR  8'h3D
`define USAR_CH_TURN_OFF   8'h2A
`define USAR_CH_REPLACE    8'h23
`define USAR_CH_ENV_ALARM  8'h26
`define USAR_CH_CFG_CHANGE 8'h5F
`define USAR_P_LINE_FAIL   0
`define USAR_P_LINE_BACK   1
`define USAR_P_BATT_LOW    2
`define USAR_P_BATT_BACK   3
`define USAR_P_ABNORMAL    4
`define USAR_P_ABN_CLEAR   5
`define USAR_P_REPLACE     6
`define USAR_P_ENV_ALARM   7
`define USAR_P_CFG_CHANGE  8
`define USAR_P_TURN_OFF    9
`define USAR_PEND_RESET    10'h010
// ----------------------------------------
// timing
// ----------------------------------------
`define USAR_CLK_HZ          25000000
`define USAR_LINE_REPEAT_S   30
`define USAR_ENV_REPEAT_MIN  2
`define USAR_REPL_REPEAT_H   5
`endif

// ---- rtl/usar_repeat_timer.v ----
// Purpose: seconds-based repeat timer for periodic alerts
// Assumes: secTick is a one-cycle pulse once per second
// Notes:   restarts from zero whenever run drops
`timescale 1ns/100ps
`default_nettype none
module usar_repeat_timer #(
   parameter CNT_W = 15,
   parameter [CNT_W-1:0] LIMIT = 15'd30
) (
   input  wire mclk,
   input  wire srst,
   input  wire run,
   input  wire secTick,
   output reg  fire
);
   reg [CNT_W-1:0] count_reg;
   always @(posedge mclk) begin
      if (srst || !run) begin
         count_reg <= {CNT_W{1'b0}};
         fire      <= 1'b0;
      end else begin
         fire <= 1'b0;
         if (secTick) begin
            if (count_reg == LIMIT - 1'b1) begin
               count_reg <= {CNT_W{1'b0}};
               fire      <= 1'b1;
            end else begin
               count_reg <= count_reg + 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- rtl/usar_top.v ----
// Purpose: ups status bytes and unprompted alert characters
// Assumes: condition pins are asynchronous; alert sink handshakes
// Notes:   registers read over avalon-mm, one wait state
`timescale 1ns/100ps
`default_nettype none
`include "usar_defs.vh"
module usar_top #(
   parameter CYCLES_PER_SEC = `USAR_CLK_HZ
) (
   input  wire        mclk,
   input  wire        srst,
   input  wire [5:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   input  wire [3:0]  optSwitch,
   input  wire        calibrating,
   input  wire        trimActive,
   input  wire        boostActive,
   input  wire        onLine,
   input  wire        onBattery,
   input  wire        overload,
   input  wire        batteryLow,
   input  wire        replaceBattery,
   input  wire [7:0]  modeIn,
   input  wire [7:0]  faultIn,
   input  wire [7:0]  shutIn,
   input  wire        statusReady,
   input  wire        envAlarm,
   input  wire        nvChange,
   input  wire        batteryTest,
   input  wire        unitOff,
   input  wire        loadOffReq,
   output reg  [7:0]  alertData,
   output reg         alertValid,
   input  wire        alertReady,
   output reg         commandsLocked
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   localparam PW = 42;
   wire [PW-1:0] pinRaw = {loadOffReq, unitOff, batteryTest, nvChange,
                           envAlarm, statusReady, shutIn, faultIn, modeIn,
                           replaceBattery, batteryLow, overload, onBattery,
                           onLine, boostActive, trimActive, calibrating,
                           optSwitch};
   reg  [PW-1:0] sync1_reg;
   reg  [PW-1:0] sync2_reg;
   reg  [PW-1:0] prev_reg;
   always @(posedge mclk) begin
      if (srst) begin
         sync1_reg <= {PW{1'b0}};
         sync2_reg <= {PW{1'b0}};
         prev_reg  <= {PW{1'b0}};
      end else begin
         sync1_reg <= pinRaw;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end
   wire [3:0] optS    = sync2_reg[3:0];
   wire [7:0] condS   = sync2_reg[11:4];
   wire [7:0] modeS   = sync2_reg[19:12];
   wire [7:0] faultS  = sync2_reg[27:20];
   wire [7:0] shutS   = sync2_reg[35:28];
   wire       readyS  = sync2_reg[36];
   wire       envS    = sync2_reg[37];
   wire       battS   = condS[4];
   wire       lowS    = condS[6];
   wire       replS   = condS[7];
   wire [PW-1:0] rise = sync2_reg & ~prev_reg;
   wire [PW-1:0] fall = ~sync2_reg & prev_reg;
   wire [7:0] abnNow  = shutS & `USAR_SHUT_ABN_MASK;
   wire [7:0] abnPrev = prev_reg[35:28] & `USAR_SHUT_ABN_MASK;

   // ----------------------------------------
   // register views
   // ----------------------------------------
   wire [7:0] optByte  = {4'h0, optS};
   // calibrating, trim, boost, line, battery, overload, low, replace in bit order
   wire [7:0] condByte = condS;
   wire [7:0] modeByte = modeS;
   wire [7:0] fltByte  = faultS;
   wire [7:0] shutByte = shutS;

   function [7:0] hexDigit;
      input [3:0] nib;
      begin
         if (nib < 4'hA)
            hexDigit = 8'h30 + {4'h0, nib};
         else
            hexDigit = 8'h37 + {4'h0, nib};
      end
   endfunction

   function [15:0] hexPair;
      input [7:0] b;
      begin
         hexPair = {hexDigit(b[7:4]), hexDigit(b[3:0])};
      end
   endfunction

   // ----------------------------------------
   // avalon-mm slave
   // ----------------------------------------
   reg  [1:0] ctrl_reg;
   reg        ack_reg;
   reg        lfSent_reg;
   reg        lbSent_reg;
   reg        abnSent_reg;
   reg        rbActive_reg;
   reg  [7:0] lastAlert_reg;
   wire       busReq = avs_read | avs_write;
   assign avs_waitrequest = busReq & ~ack_reg;
   reg  [31:0] rdNext;
   always @* begin
      rdNext = 32'h0000_0000;
      case (avs_address)
         `USAR_OFF_OPT:      rdNext[7:0] = optByte;
         `USAR_OFF_COND:     rdNext[7:0] = condByte;
         `USAR_OFF_MODE:     rdNext[7:0] = modeByte;
         `USAR_OFF_FAULT:    rdNext[7:0] = fltByte;
         `USAR_OFF_SHUT:     rdNext[7:0] = shutByte;
         `USAR_OFF_CTRL:     rdNext[1:0] = ctrl_reg;
         `USAR_OFF_STAT:     rdNext[15:0] = {lastAlert_reg, 3'h0,
                                rbActive_reg, abnSent_reg, lbSent_reg,
                                lfSent_reg, commandsLocked};
         `USAR_OFF_HEX_OPT:  rdNext[15:0] = hexPair(optByte);
         `USAR_OFF_HEX_COND: rdNext[15:0] = readyS ? hexPair(condByte)
                                                   : `USAR_NOT_READY;
         `USAR_OFF_HEX_MODE: rdNext[15:0] = hexPair(modeByte);
         `USAR_OFF_HEX_FLT:  rdNext[15:0] = hexPair(fltByte);
         `USAR_OFF_HEX_SHUT: rdNext[15:0] = hexPair(shutByte);
         default:            rdNext = 32'h0000_0000;
      endcase
   end
   // data leaves only as read answers; nothing is pushed on the bus
   always @(posedge mclk) begin
      if (srst) begin
         ack_reg      <= 1'b0;
         avs_readdata <= 32'h0000_0000;
         ctrl_reg     <= `USAR_CTRL_RESET;
      end else begin
         ack_reg <= busReq & ~ack_reg;
         if (avs_read && !ack_reg)
            avs_readdata <= rdNext;
         // after the turn-off alert writes are acknowledged but dropped
         // a write lands on the edge that completes it, waitrequest low
         if (avs_write && ack_reg && !commandsLocked &&
             avs_address == `USAR_OFF_CTRL && avs_byteenable[0])
            ctrl_reg <= avs_writedata[1:0];
      end
   end

   // ----------------------------------------
   // second tick and repeat timers
   // ----------------------------------------
   localparam CW = 26;
   localparam [31:0] SEC_L32  = CYCLES_PER_SEC - 1;
   localparam [31:0] LINE_L32 = `USAR_LINE_REPEAT_S;
   localparam [31:0] ENV_L32  = `USAR_ENV_REPEAT_MIN * 60;
   localparam [31:0] REPL_L32 = `USAR_REPL_REPEAT_H * 3600;
   localparam [CW-1:0] SEC_LAST = SEC_L32[CW-1:0];
   localparam [14:0] LINE_S = LINE_L32[14:0];
   localparam [14:0] ENV_S  = ENV_L32[14:0];
   localparam [14:0] REPL_S = REPL_L32[14:0];
   reg [CW-1:0] secCnt_reg;
   reg          secTick;
   always @(posedge mclk) begin
      if (srst) begin
         secCnt_reg <= {CW{1'b0}};
         secTick    <= 1'b0;
      end else begin
         secTick <= (secCnt_reg == SEC_LAST);
         if (secCnt_reg == SEC_LAST)
            secCnt_reg <= {CW{1'b0}};
         else
            secCnt_reg <= secCnt_reg + 1'b1;
      end
   end
   wire lineFire;
   wire envFire;
   wire replFire;
   wire envOn = envS & ctrl_reg[`USAR_CTRL_ENV_EN];
   usar_repeat_timer #(.CNT_W(15), .LIMIT(LINE_S)) lineTimer (
      .mclk    (mclk),
      .srst    (srst),
      .run     (battS & ~lowS),
      .secTick (secTick),
      .fire    (lineFire)
   );
   usar_repeat_timer #(.CNT_W(15), .LIMIT(ENV_S)) envTimer (
      .mclk    (mclk),
      .srst    (srst),
      .run     (envOn),
      .secTick (secTick),
      .fire    (envFire)
   );
   usar_repeat_timer #(.CNT_W(15), .LIMIT(REPL_S)) replTimer (
      .mclk    (mclk),
      .srst    (srst),
      .run     (rbActive_reg),
      .secTick (secTick),
      .fire    (replFire)
   );

   // ----------------------------------------
   // alert events
   // ----------------------------------------
   reg [9:0] evt;
   always @* begin
      evt = 10'h000;
      evt[`USAR_P_LINE_FAIL]  = rise[8] | (lineFire & battS & ~lowS);
      evt[`USAR_P_LINE_BACK]  = fall[8] & lfSent_reg;
      evt[`USAR_P_BATT_LOW]   = rise[10];
      evt[`USAR_P_BATT_BACK]  = fall[10] & lbSent_reg;
      evt[`USAR_P_ABNORMAL]   = (abnNow != abnPrev) &&
                                (abnNow != 8'h00);
      evt[`USAR_P_ABN_CLEAR]  = (abnPrev != 8'h00) && (abnNow == 8'h00) &&
                                abnSent_reg;
      evt[`USAR_P_REPLACE]    = rise[11] | (replFire & rbActive_reg);
      evt[`USAR_P_ENV_ALARM]  = (rise[37] & envOn) | (envFire & envOn);
      evt[`USAR_P_CFG_CHANGE] = rise[38];
      evt[`USAR_P_TURN_OFF]   = rise[41];
   end

   // ----------------------------------------
   // pending alerts and sender
   // ----------------------------------------
   // one pending bit per character: repeats collapse, none are lost
   reg [9:0] pend_reg;
   reg [3:0] pick;
   reg       pickAny;
   integer   i;
   always @* begin
      pick    = 4'h0;
      pickAny = 1'b0;
      for (i = 0; i < 10; i = i + 1) begin
         if (pend_reg[i]) begin
            pick    = i[3:0];
            pickAny = 1'b1;
         end
      end
   end

   function [7:0] alertChar;
      input [3:0] idx;
      begin
         case (idx)
            `USAR_P_LINE_FAIL:  alertChar = `USAR_CH_LINE_FAIL;
            `USAR_P_LINE_BACK:  alertChar = `USAR_CH_LINE_BACK;
            `USAR_P_BATT_LOW:   alertChar = `USAR_CH_BATT_LOW;
            `USAR_P_BATT_BACK:  alertChar = `USAR_CH_BATT_BACK;
            `USAR_P_ABNORMAL:   alertChar = `USAR_CH_ABNORMAL;
            `USAR_P_ABN_CLEAR:  alertChar = `USAR_CH_ABN_CLEAR;
            `USAR_P_REPLACE:    alertChar = `USAR_CH_REPLACE;
            `USAR_P_ENV_ALARM:  alertChar = `USAR_CH_ENV_ALARM;
            `USAR_P_CFG_CHANGE: alertChar = `USAR_CH_CFG_CHANGE;
            default:            alertChar = `USAR_CH_TURN_OFF;
         endcase
      end
   endfunction

   wire       sendDone  = alertValid & alertReady;
   wire       alertEn   = ctrl_reg[`USAR_CTRL_ALERT_EN];
   wire       canLoad   = (~alertValid | alertReady) & pickAny & alertEn;
   reg  [9:0] clrMask;
   reg  [3:0] busy_reg;
   always @* begin
      clrMask = 10'h000;
      if (canLoad)
         clrMask[pick] = 1'b1;
   end
   // power-on abnormal alert is preloaded in the reset value
   always @(posedge mclk) begin
      if (srst) begin
         pend_reg   <= `USAR_PEND_RESET;
         alertValid <= 1'b0;
         alertData  <= 8'h00;
         busy_reg   <= 4'h0;
      end else begin
         // set wins over the clear of the slot being loaded
         pend_reg <= (pend_reg & ~clrMask) | evt;
         if (canLoad) begin
            alertValid <= 1'b1;
            alertData  <= alertChar(pick);
            busy_reg   <= pick;
         end else if (sendDone) begin
            alertValid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // alert history flags
   // ----------------------------------------
   wire sentLf  = sendDone && busy_reg == `USAR_P_LINE_FAIL;
   wire sentLb  = sendDone && busy_reg == `USAR_P_BATT_LOW;
   wire sentOff = sendDone && busy_reg == `USAR_P_TURN_OFF;
   wire sentAbn = sendDone && busy_reg == `USAR_P_ABNORMAL && abnNow != 8'h00;
   always @(posedge mclk) begin
      if (srst) begin
         lfSent_reg     <= 1'b0;
         lbSent_reg     <= 1'b0;
         abnSent_reg    <= 1'b0;
         rbActive_reg   <= 1'b0;
         commandsLocked <= 1'b0;
         lastAlert_reg  <= 8'h00;
      end else begin
         if (sendDone)
            lastAlert_reg <= alertData;
         if (sentLf)
            lfSent_reg <= 1'b1;
         else if (fall[8])
            lfSent_reg <= 1'b0;
         if (sentLb)
            lbSent_reg <= 1'b1;
         else if (fall[10])
            lbSent_reg <= 1'b0;
         // the power-on copy finds no shutdown cause and is not armed
         if (sentAbn)
            abnSent_reg <= 1'b1;
         else if (abnNow == 8'h00)
            abnSent_reg <= 1'b0;
         if (rise[11])
            rbActive_reg <= 1'b1;
         else if (rise[39] || rise[40])
            rbActive_reg <= 1'b0;
         // held until reset: the unit is about to drop the load
         if (sentOff)
            commandsLocked <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- verif/usar_alert_sink.sv ----
// Purpose: host-side sink for the unprompted alert characters
// Assumes: one character per valid/ready transfer
// Notes:   stall lets the bench hold off the stream
`timescale 1ns/100ps
`default_nettype none
module usar_alert_sink (
   input  wire logic       mclk,
   input  wire logic [7:0] alertData,
   input  wire logic       alertValid,
   input  wire logic       stall,
   output var  logic       alertReady
);
   // counts per character; never cleared so the bench works in deltas
   int cnt [256] = '{default: 0};
   assign alertReady = ~stall;
   always @(posedge mclk) begin
      if (alertValid && alertReady) begin
         cnt[alertData] <= cnt[alertData] + 1;
      end
   end
endmodule
`default_nettype wire

// ---- verif/usar_top_sva.sv ----
// Purpose: port-level checks of the status and alert reporter
// Assumes: one clock domain, srst synchronous active high
// Notes:   bound to usar_top below
`timescale 1ns/100ps
`default_nettype none
`include "usar_defs.vh"
module usar_top_sva (
   input wire logic        mclk,
   input wire logic        srst,
   input wire logic [5:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [7:0]  alertData,
   input wire logic        alertValid,
   input wire logic        alertReady,
   input wire logic        commandsLocked
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   logic rdDone;
   logic starTaken;
   function automatic logic isHex(input logic [7:0] c);
      return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
   endfunction
   assign rdDone = avs_read && !avs_waitrequest;
   always @(posedge mclk) begin
      starTaken <= alertValid && alertReady && alertData == `USAR_CH_TURN_OFF;
   end
   property p_bus_answer;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest || !(avs_read || avs_write);
   endproperty
   a_bus_answer: assert property (p_bus_answer)
      else $error("bus request not answered after one wait");
   property p_idle_nowait;
      !(avs_read || avs_write) |-> !avs_waitrequest;
   endproperty
   a_idle_nowait: assert property (p_idle_nowait)
      else $error("waitrequest high without a request");
   property p_alert_stand;
      alertValid && !alertReady |=> alertValid && $stable(alertData);
   endproperty
   a_alert_stand: assert property (p_alert_stand)
      else $error("alert character changed before acceptance");
   property p_alert_char;
      alertValid |-> alertData inside {8'h21, 8'h24, 8'h25, 8'h2B, 8'h3F,
                                       8'h3D, 8'h2A, 8'h23, 8'h26, 8'h5F};
   endproperty
   a_alert_char: assert property (p_alert_char)
      else $error("alert character outside the alert set");
   property p_power_on;
      $fell(srst) |=> alertValid && alertData == 8'h3F;
   endproperty
   a_power_on: assert property (p_power_on)
      else $error("no abnormal alert after power-on");
   property p_lock_keep;
      commandsLocked |=> commandsLocked;
   endproperty
   a_lock_keep: assert property (p_lock_keep)
      else $error("command lock dropped without reset");
   property p_lock_cause;
      $rose(commandsLocked) |-> starTaken;
   endproperty
   a_lock_cause: assert property (p_lock_cause)
      else $error("lock rose without turn-off alert accepted");
   property p_hex_digits;
      rdDone && avs_address inside {6'h20, 6'h28, 6'h2C, 6'h30} |->
         avs_readdata[31:16] == 16'h0 && isHex(avs_readdata[15:8]) && isHex(avs_readdata[7:0]);
   endproperty
   a_hex_digits: assert property (p_hex_digits)
      else $error("hex view not two uppercase digits");
   property p_opt_unused;
      rdDone && avs_address == `USAR_OFF_OPT |-> avs_readdata[31:4] == 28'h0;
   endproperty
   a_opt_unused: assert property (p_opt_unused)
      else $error("unused option bits not zero");
endmodule
bind usar_top usar_top_sva i_usar_top_sva (.mclk(mclk), .srst(srst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .alertData(alertData), .alertValid(alertValid), .alertReady(alertReady),
   .commandsLocked(commandsLocked));
`default_nettype wire

// ---- verif/usar_top_tb.sv ----
// Purpose: self-checking bench of the status and alert reporter
// Assumes: one second shortened to 2 mclk cycles
// Notes:   alert checks count characters seen by the sink
`timescale 1ns/100ps
`default_nettype none
`include "usar_defs.vh"
`define CHK(nm, exp, got) begin \
   checks_done++; \
   if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
   end \
end
module usar_top_tb;
   logic mclk = 0, srst = 1, avs_read = 0, avs_write = 0, statusReady = 1, envAlarm = 0;
   logic nvChange = 0, batteryTest = 0, loadOffReq = 0, stall = 0, unitOff = 0;
   logic [5:0] avs_address = 0;
   logic [31:0] avs_writedata = 0, d;
   logic [3:0] optSwitch = 0;
   logic [7:0] condVec = 8'h08, modeIn = 0, faultIn = 0, shutIn = 0;
   wire logic [31:0] rdData;
   wire logic waitReq, alertValid, alertReady, commandsLocked;
   wire logic [7:0] alertData;
   int n_mismatch = 0, checks_done = 0, base [256] = '{default: 0};
   usar_top #(.CYCLES_PER_SEC(2)) i_usar_top (.mclk(mclk), .srst(srst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(rdData),
      .avs_waitrequest(waitReq), .optSwitch(optSwitch), .calibrating(condVec[0]),
      .trimActive(condVec[1]), .boostActive(condVec[2]), .onLine(condVec[3]),
      .onBattery(condVec[4]), .overload(condVec[5]), .batteryLow(condVec[6]),
      .replaceBattery(condVec[7]), .modeIn(modeIn), .faultIn(faultIn), .shutIn(shutIn),
      .statusReady(statusReady), .envAlarm(envAlarm), .nvChange(nvChange),
      .batteryTest(batteryTest), .unitOff(unitOff), .loadOffReq(loadOffReq),
      .alertData(alertData), .alertValid(alertValid), .alertReady(alertReady),
      .commandsLocked(commandsLocked));
   usar_alert_sink i_usar_alert_sink (.mclk(mclk), .alertData(alertData),
      .alertValid(alertValid), .stall(stall), .alertReady(alertReady));
   initial begin
      forever #20 mclk = ~mclk;
   end
   // ----------------------------------------
   // bus and alert helpers
   // ----------------------------------------
   task automatic waitCyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // request held until waitrequest is seen low at a rising edge
   task automatic avXfer(input logic wr, input logic [5:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= ~wr;
      avs_write <= wr;
      do begin
         @(posedge mclk);
         n++;
      end while (waitReq !== 1'b0 && n < 50);
      `CHK("bus wait", 1'b0, waitReq)
      d = rdData;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic snap;
      for (int i = 0; i < 256; i++) base[i] = i_usar_alert_sink.cnt[i];
   endtask
   task automatic expectDelta(input logic [7:0] c, input int lo, input int hi);
      int n;
      n = i_usar_alert_sink.cnt[c] - base[c];
      `CHK("alert count", 1'b1, (n >= lo && n <= hi))
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_power;
      waitCyc(20);
      expectDelta(8'h3F, 1, 1);
      expectDelta(8'h3D, 0, 0);
      $display("test power-on done");
   endtask
   task automatic t_regs;
      for (int v = 0; v < 16; v++) begin
         optSwitch <= v[3:0];
         waitCyc(5);
         avXfer(0, `USAR_OFF_OPT, 0);
         `CHK("option", {28'h0, v[3:0]}, d)
      end
      for (int i = 0; i < 8; i++) begin
         condVec <= 8'h01 << i;
         modeIn <= 8'h01 << i;
         faultIn <= 8'h80 >> i;
         waitCyc(5);
         avXfer(0, `USAR_OFF_COND, 0);
         `CHK("status", {24'h0, 8'h01 << i}, d)
         avXfer(0, `USAR_OFF_MODE, 0);
         `CHK("mode", {24'h0, 8'h01 << i}, d)
         avXfer(0, `USAR_OFF_FAULT, 0);
         `CHK("fault", {24'h0, 8'h80 >> i}, d)
      end
      shutIn <= 8'h99;
      modeIn <= 8'hA5;
      condVec <= 8'h50;
      statusReady <= 1'b0;
      waitCyc(5);
      avXfer(0, `USAR_OFF_SHUT, 0);
      `CHK("shutdown", 32'h99, d)
      avXfer(0, `USAR_OFF_COND, 0);
      `CHK("battery low status", 32'h50, d)
      avXfer(0, `USAR_OFF_HEX_COND, 0);
      `CHK("status not ready", 32'h534D, d)
      statusReady <= 1'b1;
      waitCyc(5);
      avXfer(0, `USAR_OFF_HEX_COND, 0);
      `CHK("status retry", 32'h3530, d)
      avXfer(0, `USAR_OFF_HEX_MODE, 0);
      `CHK("mode hex", 32'h4135, d)
      avXfer(0, 6'h3C, 0);
      `CHK("unmapped", 32'h0, d)
      shutIn <= 8'h00;
      condVec <= 8'h08;
      waitCyc(30);
      $display("test regs done");
   endtask
   task automatic t_line;
      snap;
      condVec <= 8'h10;
      waitCyc(150);
      expectDelta(8'h21, 3, 5);
      snap;
      condVec <= 8'h50;
      waitCyc(20);
      expectDelta(8'h25, 1, 1);
      snap;
      waitCyc(150);
      expectDelta(8'h21, 0, 0);
      snap;
      condVec <= 8'h08;
      waitCyc(20);
      expectDelta(8'h24, 1, 1);
      expectDelta(8'h2B, 1, 1);
      $display("test line done");
   endtask
   task automatic t_shut;
      snap;
      shutIn <= 8'h02;
      waitCyc(20);
      expectDelta(8'h3F, 1, 1);
      snap;
      shutIn <= 8'h00;
      waitCyc(20);
      expectDelta(8'h3D, 1, 1);
      snap;
      shutIn <= 8'h08;
      waitCyc(20);
      expectDelta(8'h3F, 0, 0);
      shutIn <= 8'h00;
      $display("test shutdown done");
   endtask
   // an event raised while alerts are off must wait, not vanish
   task automatic t_cfg;
      avXfer(1, `USAR_OFF_CTRL, 32'h2);
      snap;
      nvChange <= 1'b1;
      waitCyc(4);
      nvChange <= 1'b0;
      waitCyc(20);
      expectDelta(8'h5F, 0, 0);
      stall <= 1'b1;
      avXfer(1, `USAR_OFF_CTRL, 32'h3);
      waitCyc(20);
      stall <= 1'b0;
      waitCyc(10);
      expectDelta(8'h5F, 1, 1);
      snap;
      envAlarm <= 1'b1;
      waitCyc(500);
      expectDelta(8'h26, 2, 3);
      envAlarm <= 1'b0;
      waitCyc(20);
      snap;
      waitCyc(300);
      expectDelta(8'h26, 0, 0);
      snap;
      condVec <= 8'h88;
      waitCyc(36100);
      expectDelta(8'h23, 2, 2);
      batteryTest <= 1'b1;
      waitCyc(4);
      batteryTest <= 1'b0;
      waitCyc(5);
      avXfer(0, `USAR_OFF_STAT, 0);
      `CHK("repeat after test", 1'b0, d[4])
      condVec <= 8'h08;
      waitCyc(5);
      condVec <= 8'h88;
      waitCyc(5);
      avXfer(0, `USAR_OFF_STAT, 0);
      `CHK("repeat armed", 1'b1, d[4])
      unitOff <= 1'b1;
      waitCyc(4);
      unitOff <= 1'b0;
      waitCyc(5);
      avXfer(0, `USAR_OFF_STAT, 0);
      `CHK("repeat after off", 1'b0, d[4])
      $display("test alerts done");
   endtask
   task automatic t_lock;
      snap;
      loadOffReq <= 1'b1;
      waitCyc(4);
      loadOffReq <= 1'b0;
      waitCyc(20);
      expectDelta(8'h2A, 1, 1);
      `CHK("locked", 1'b1, commandsLocked)
      avXfer(1, `USAR_OFF_CTRL, 32'h0);
      avXfer(0, `USAR_OFF_CTRL, 0);
      `CHK("control after lock", 32'h3, d)
      $display("test lock done");
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      waitCyc(10);
      srst <= 1'b0;
      t_power;
      t_regs;
      t_line;
      t_shut;
      t_cfg;
      t_lock;
      test_done;
   end
   initial begin
      waitCyc(60000);
      n_mismatch++;
      test_done;
   end
endmodule
`default_nettype wire
